// ---- src/ascp_device.sv ----
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`default_nettype none
// How it works
// RULE1 - frame starts: select low, then rising clock
// RULE2 - select high ignores all cycles
// RULE3 - bytes continue while select stays low
// RULE4 - select pause between bytes resumes frame
// RULE5 - select held high: pins high-z, straps
// RULE6 - sixteen bit instruction opens each frame
// RULE7 - word bits set byte count, bytes eight
// RULE8 - instruction flags read or write
// RULE9 - data line turns to output on readback
// RULE10 - input sampled on rising shift clock
// RULE11 - MSB first default, config selects LSB
// RULE12 - four pins read as straps when unused
// RULE13 - stabiliser strap high enables, default
// RULE14 - oe, format, powerdown strap polarities
// RULE15 - board ties select high for straps
// RULE16 - host idles port for full performance
// RULE17 - mirrored nibbles decode in either order
// RULE18 - read bits driven on falling edge
// RULE19 - rw, two length bits, 13-bit address
module ascp_device (
   input wire logic clk_i,
   input wire logic rst_i,
   ascp_if.device link,
   output logic duty_cycle_stabiliser_o,
   output logic twos_complement_o,
   output logic outputs_hiz_o,
   output logic power_down_o,
   output logic strap_mode_o,
   output logic lsb_first_o
);
   logic [3:0] pins_s;
   logic cs_n_s, sck_s, sdi_s, mon_sdo_s, mon_sck_s;
   logic sck_d_reg;
   logic rise, fall, active;
   ascp_pkg::ascp_phase_e phase_reg;
   logic [3:0] bit_cnt_reg;
   logic [15:0] instr_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic [12:0] addr_reg;
   logic [2:0] bytes_left_reg;
   logic streaming_reg;
   logic [7:0] mem [ascp_pkg::REG_DEPTH];
   logic [7:0] cfg_reg;
   logic [7:0] settle_reg;
   logic strap_done_reg;
   logic sdo_reg, oe_reg;
   logic is_read;
   logic [7:0] rx_byte;

   ascp_sync #(.W(4)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({link.port_select_n, link.shift_clock, link.sdio_line, link.mon_sdo_strap}),
      .q_o(pins_s)
   );
   ascp_sync #(.W(1)) u_sync2 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(link.mon_sclk_strap),
      .q_o(mon_sck_s)
   );
   assign {cs_n_s, sck_s, sdi_s, mon_sdo_s} = pins_s;

   function automatic logic [7:0] bit_rev(input logic [7:0] v);
      for (int i = 0; i < 8; i++)
      begin
         bit_rev[i] = v[7-i];
      end
   endfunction

   function automatic logic [7:0] read_byte(input logic [12:0] a, input logic [7:0] cfg);
      if (a == ascp_pkg::CFG_ADDR)
         read_byte = cfg;
      else if (a == ascp_pkg::ID_ADDR)
         read_byte = ascp_pkg::ID_VALUE;
      else
         read_byte = 8'h00;
   endfunction

   assign rise = sck_s & ~sck_d_reg; // [RULE10]
   assign fall = ~sck_s & sck_d_reg;
   assign active = ~cs_n_s & ~strap_mode_o; // [RULE2]
   assign is_read = instr_reg[15]; // [RULE8]
   // lsb-first bytes arrive reversed; normalise once here
   assign rx_byte = lsb_first_o ? bit_rev({shift_reg[6:0], sdi_s}) : {shift_reg[6:0], sdi_s};
   assign lsb_first_o = cfg_reg[ascp_pkg::CFG_LSB_HI] | cfg_reg[ascp_pkg::CFG_LSB_LO]; // [RULE11]

   // ----------------------------------------
   // strap capture after reset
   // ----------------------------------------
   // settle window lets the synchronisers fill before straps are judged
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         settle_reg <= 8'h00;
         strap_done_reg <= 1'b0;
         strap_mode_o <= 1'b0;
         duty_cycle_stabiliser_o <= 1'b1;
         twos_complement_o <= 1'b0;
         outputs_hiz_o <= 1'b0;
         power_down_o <= 1'b0;
      end
      else if (!strap_done_reg)
      begin
         settle_reg <= settle_reg + 8'h01;
         if (settle_reg == 8'(ascp_pkg::STRAP_SETTLE_CYCLES))
         begin
            strap_done_reg <= 1'b1;
            if (cs_n_s) // [RULE12]
            begin
               strap_mode_o <= 1'b1;
               duty_cycle_stabiliser_o <= sdi_s; // [RULE13]
               twos_complement_o <= sck_s; // [RULE14]
               outputs_hiz_o <= mon_sdo_s; // [RULE14]
               power_down_o <= mon_sck_s; // [RULE14]
            end
         end
      end
      // select seen low: the port is in use after all, straps stay latched [RULE5]
      else if (!cs_n_s)
         strap_mode_o <= 1'b0;
   end

   // ----------------------------------------
   // frame sequencer
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sck_d_reg <= 1'b0;
         phase_reg <= ascp_pkg::ASCP_IDLE;
         bit_cnt_reg <= 4'h0;
         instr_reg <= 16'h0000;
         shift_reg <= 8'h00;
         addr_reg <= 13'h0000;
         bytes_left_reg <= 3'h0;
         streaming_reg <= 1'b0;
      end
      else
      begin
         sck_d_reg <= sck_s;
         if (!active)
         begin
            // counters hold, so a select pause between bytes resumes [RULE4]
            if (phase_reg == ascp_pkg::ASCP_INSTR && bit_cnt_reg == 4'h0)
               phase_reg <= ascp_pkg::ASCP_IDLE;
         end
         else if (rise)
         begin
            case (phase_reg)
               ascp_pkg::ASCP_IDLE:
               begin
                  phase_reg <= ascp_pkg::ASCP_INSTR; // [RULE1]
                  instr_reg <= {15'h0000, sdi_s};
                  bit_cnt_reg <= 4'h1;
               end
               ascp_pkg::ASCP_INSTR:
               begin
                  instr_reg <= {instr_reg[14:0], sdi_s}; // [RULE6]
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg == ascp_pkg::BIT_CNT_LAST)
                  begin
                     phase_reg <= ascp_pkg::ASCP_DATA;
                     bit_cnt_reg <= 4'h0;
                     addr_reg <= {instr_reg[11:0], sdi_s}; // [RULE19]
                     bytes_left_reg <= {1'b0, instr_reg[13:12]}; // [RULE7]
                     streaming_reg <= (instr_reg[13:12] == 2'b11); // [RULE3]
                  end
               end
               ascp_pkg::ASCP_DATA:
               begin
                  shift_reg <= {shift_reg[6:0], sdi_s};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg[2:0] == ascp_pkg::DATA_CNT_LAST)
                  begin
                     bit_cnt_reg <= 4'h0;
                     addr_reg <= lsb_first_o ? addr_reg + 13'h0001 : addr_reg - 13'h0001; // [RULE19]
                     if (!streaming_reg)
                     begin
                        if (bytes_left_reg == 3'h0)
                           phase_reg <= ascp_pkg::ASCP_IDLE; // [RULE7]
                        else
                           bytes_left_reg <= bytes_left_reg - 3'h1;
                     end
                  end
               end
               default: phase_reg <= ascp_pkg::ASCP_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cfg_reg <= ascp_pkg::CFG_RESET_VALUE; // [RULE11]
      else if (active && rise && phase_reg == ascp_pkg::ASCP_DATA && !is_read &&
               bit_cnt_reg[2:0] == ascp_pkg::DATA_CNT_LAST)
      begin
         if (addr_reg == ascp_pkg::CFG_ADDR)
         begin
            // either half of the mirrored pair sets the bit [RULE17]
            if (rx_byte[ascp_pkg::CFG_RST_HI] | rx_byte[ascp_pkg::CFG_RST_LO])
               cfg_reg <= ascp_pkg::CFG_RESET_VALUE;
            else
               cfg_reg <= {1'b0, rx_byte[ascp_pkg::CFG_LSB_HI] | rx_byte[ascp_pkg::CFG_LSB_LO],
                           1'b0, 2'b11, 1'b0,
                           rx_byte[ascp_pkg::CFG_LSB_HI] | rx_byte[ascp_pkg::CFG_LSB_LO],
                           1'b0}; // [RULE17]
         end
         else
            mem[addr_reg[ascp_pkg::REG_IDX_BITS-1:0]] <= rx_byte;
      end
   end

   // ----------------------------------------
   // readback driver
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sdo_reg <= 1'b0;
         oe_reg <= 1'b0;
         tx_reg <= 8'h00;
      end
      else if (!active || phase_reg != ascp_pkg::ASCP_DATA || !is_read)
      begin
         oe_reg <= 1'b0; // [RULE5] [RULE2]
         if (phase_reg == ascp_pkg::ASCP_INSTR && bit_cnt_reg == ascp_pkg::BIT_CNT_LAST)
            tx_reg <= 8'h00;
      end
      else if (fall) // [RULE18]
      begin
         oe_reg <= 1'b1; // [RULE9]
         if (bit_cnt_reg[2:0] == 3'h0)
         begin
            logic [7:0] b;
            b = (addr_reg == ascp_pkg::CFG_ADDR || addr_reg == ascp_pkg::ID_ADDR) ?
                read_byte(addr_reg, cfg_reg) : mem[addr_reg[ascp_pkg::REG_IDX_BITS-1:0]];
            b = lsb_first_o ? bit_rev(b) : b;
            sdo_reg <= b[7];
            tx_reg <= {b[6:0], 1'b0};
         end
         else
         begin
            sdo_reg <= tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
         end
      end
   end

   assign link.sdio_dev_o = sdo_reg;
   assign link.sdio_dev_oe = oe_reg;
endmodule // ascp_device
`default_nettype wire

// ---- src/ascp_pkg.sv ----
`default_nettype none
package ascp_pkg;
   localparam int INSTR_BITS = 16;
   localparam int WORD_BITS = 8;
   localparam int ADDR_BITS = 13;
   localparam logic [3:0] BIT_CNT_LAST = 4'hF;
   localparam logic [2:0] DATA_CNT_LAST = 3'h7;
   localparam logic [12:0] CFG_ADDR = 13'h0000;
   localparam logic [7:0] CFG_RESET_VALUE = 8'h18;
   localparam int CFG_LSB_HI = 6;
   localparam int CFG_RST_HI = 5;
   localparam int CFG_RST_LO = 2;
   localparam int CFG_LSB_LO = 1;
   localparam int STRAP_SETTLE_CYCLES = 4;
   localparam int SCK_HALF_DIV = 4;
   localparam int REG_DEPTH = 64;
   localparam int REG_IDX_BITS = 6;
   localparam logic [7:0] ID_VALUE = 8'h5A; // arbitrary identification value
   localparam logic [12:0] ID_ADDR = 13'h0001;
   localparam logic [7:0] WB_CTRL = 8'h00;
   localparam logic [7:0] WB_ADDR = 8'h04;
   localparam logic [7:0] WB_WDATA = 8'h08;
   localparam logic [7:0] WB_RDATA = 8'h0C;
   localparam logic [7:0] WB_STATUS = 8'h10;
   typedef enum logic [1:0] {ASCP_IDLE, ASCP_INSTR, ASCP_DATA} ascp_phase_e;
endpackage
`default_nettype wire

// ---- src/ascp_if.sv ----
`default_nettype none
interface ascp_if;
   logic port_select_n;
   logic shift_clock;
   logic sdio_host_o;
   logic sdio_host_oe;
   logic sdio_dev_o;
   logic sdio_dev_oe;
   logic sdio_line;
   logic mon_sdo_strap;
   logic mon_sclk_strap;
   assign sdio_line = sdio_host_oe ? sdio_host_o : (sdio_dev_oe ? sdio_dev_o : 1'b1);
   modport host (output port_select_n, output shift_clock, output sdio_host_o,
      output sdio_host_oe, input sdio_line);
   modport device (input port_select_n, input shift_clock, input sdio_line,
      output sdio_dev_o, output sdio_dev_oe, input mon_sdo_strap, input mon_sclk_strap);
endinterface
`default_nettype wire

// ---- src/ascp_sync.sv ----
`default_nettype none
module ascp_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta_reg <= '0;
         q_o <= '0;
      end
      else
      begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule // ascp_sync
`default_nettype wire

// ---- src/ascp_host.sv ----
`default_nettype none
module ascp_host (
   input wire logic clk_i,
   input wire logic rst_i,
   ascp_if.host link,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   logic [31:0] ctrl_reg; // [0]=go(pulse) [1]=read [2]=lsb first
   logic [12:0] addr_reg;
   logic [7:0] wdata_reg, rdata_reg;
   logic busy_reg;
   logic [23:0] sh_reg;
   logic [4:0] cnt_reg;
   logic [2:0] div_reg;
   logic sck_reg, cs_n_reg, oe_reg, rd_reg, lsb_reg;
   logic [1:0] sdi_s;
   logic req;
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   function automatic logic [7:0] rev8(input logic [7:0] v);
      for (int i = 0; i < 8; i++)
      begin
         rev8[i] = v[7-i];
      end
   endfunction

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         sdi_s <= 2'b00;
      else
         sdi_s <= {sdi_s[0], link.sdio_line};
   end

   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         ctrl_reg <= 32'h00000000;
         addr_reg <= 13'h0000;
         wdata_reg <= 8'h00;
      end
      else
      begin
         wb_ack_o <= req;
         ctrl_reg[0] <= 1'b0;
         if (req && wb_we_i && wb_sel_i[0])
         begin
            case (wb_adr_i)
               ascp_pkg::WB_CTRL: ctrl_reg[2:0] <= {wb_dat_i[2:1], wb_dat_i[0] & ~busy_reg};
               ascp_pkg::WB_ADDR: addr_reg[7:0] <= wb_dat_i[7:0];
               ascp_pkg::WB_WDATA: wdata_reg <= wb_dat_i[7:0];
               default: ;
            endcase
         end
         if (req && wb_we_i && wb_sel_i[1] && wb_adr_i == ascp_pkg::WB_ADDR)
            addr_reg[12:8] <= wb_dat_i[12:8];
         case (wb_adr_i)
            ascp_pkg::WB_CTRL: wb_dat_o <= {29'h0, ctrl_reg[2:1], 1'b0};
            ascp_pkg::WB_ADDR: wb_dat_o <= {19'h0, addr_reg};
            ascp_pkg::WB_WDATA: wb_dat_o <= {24'h0, wdata_reg};
            ascp_pkg::WB_RDATA: wb_dat_o <= {24'h0, rdata_reg};
            ascp_pkg::WB_STATUS: wb_dat_o <= {31'h0, busy_reg};
            default: wb_dat_o <= 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------
   // serial engine: one-byte frames, clock from divider
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         busy_reg <= 1'b0;
         sh_reg <= 24'h000000;
         cnt_reg <= 5'h00;
         div_reg <= 3'h0;
         sck_reg <= 1'b0;
         cs_n_reg <= 1'b1;
         oe_reg <= 1'b0;
         rd_reg <= 1'b0;
         lsb_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end
      else if (!busy_reg)
      begin
         sck_reg <= 1'b0;
         cs_n_reg <= 1'b1;
         oe_reg <= 1'b0;
         if (ctrl_reg[0])
         begin
            busy_reg <= 1'b1;
            rd_reg <= ctrl_reg[1];
            lsb_reg <= ctrl_reg[2];
            sh_reg <= {ctrl_reg[1], 2'b00, addr_reg,
                       ctrl_reg[2] ? rev8(wdata_reg) : wdata_reg}; // [RULE19]
            cnt_reg <= 5'h00;
            div_reg <= 3'h0;
            cs_n_reg <= 1'b0; // [RULE1]
            oe_reg <= 1'b1;
         end
      end
      else
      begin
         div_reg <= div_reg + 3'h1;
         if (div_reg == 3'(ascp_pkg::SCK_HALF_DIV - 1))
         begin
            div_reg <= 3'h0;
            if (!sck_reg)
            begin
               sck_reg <= 1'b1;
            end
            else
            begin
               sck_reg <= 1'b0;
               cnt_reg <= cnt_reg + 5'h01;
               sh_reg <= {sh_reg[22:0], 1'b0};
               // synced line lags the pin, so a read bit is taken at the fall after its rise
               if (cnt_reg >= 5'h10 && rd_reg)
                  rdata_reg <= (cnt_reg == 5'h17 && lsb_reg) ? rev8({rdata_reg[6:0], sdi_s[1]}) :
                               {rdata_reg[6:0], sdi_s[1]};
               if (cnt_reg == 5'h0F && rd_reg)
                  oe_reg <= 1'b0; // release line for readback
               if (cnt_reg == 5'h17)
               begin
                  busy_reg <= 1'b0;
                  cs_n_reg <= 1'b1;
                  oe_reg <= 1'b0;
               end
            end
         end
      end
   end

   assign link.port_select_n = cs_n_reg;
   assign link.shift_clock = sck_reg;
   assign link.sdio_host_o = sh_reg[23];
   assign link.sdio_host_oe = oe_reg;
endmodule // ascp_host
`default_nettype wire

// ---- tb/ascp_checker.sv ----
`default_nettype none
module ascp_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic port_select_n,
   input wire logic shift_clock,
   input wire logic sdio_host_o,
   input wire logic sdio_host_oe,
   input wire logic sdio_dev_o,
   input wire logic sdio_dev_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic sck_q;
   logic [5:0] edge_cnt;
   // ----------
   // helpers
   // ----------
   always_ff @(posedge clk_i)
   begin
      sck_q <= shift_clock;
   end
   // keeps its count until the edge that sees select high
   always_ff @(posedge clk_i)
   begin
      if (rst_i || port_select_n)
         edge_cnt <= 6'h00;
      else if (shift_clock && !sck_q)
         edge_cnt <= edge_cnt + 6'h01;
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ----------
   // properties
   // ----------
   sck_while_sel_a: assert property ($rose(shift_clock) |-> !port_select_n)
      else $error("shift clock rose while deselected");
   sel_then_clock_a: assert property ($fell(port_select_n) |-> !shift_clock ##1 !shift_clock)
      else $error("select fell with clock not low");
   dev_quiet_a: assert property (port_select_n |-> !sdio_dev_oe)
      else $error("device drives data while deselected");
   no_fight_a: assert property (!(sdio_host_oe && sdio_dev_oe))
      else $error("both ends drive the data line");
   turn_point_a: assert property ($rose(sdio_dev_oe) |-> edge_cnt == 6'h10 && !sdio_host_oe)
      else $error("data line turned at wrong point");
   frame_len_a: assert property ($rose(port_select_n) |-> edge_cnt == 6'h18)
      else $error("frame did not carry instruction and one byte");
   host_hold_a: assert property (shift_clock && sck_q && sdio_host_oe |-> $stable(sdio_host_o))
      else $error("host data moved while clock high");
   dev_fall_a: assert property (shift_clock && sck_q && sdio_dev_oe |-> $stable(sdio_dev_o))
      else $error("device data moved while clock high");
   clock_high_a: assert property ($rose(shift_clock) |-> shift_clock[*4])
      else $error("shift clock high phase too short");
   cover property ($rose(sdio_dev_oe));
   cover property ($rose(port_select_n));
   cover property ($fell(port_select_n));
endmodule // ascp_checker
`default_nettype wire

// ---- tb/tb_adc_serial_config_port.sv ----
`default_nettype none
module tb_adc_serial_config_port;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [12:0] a; logic [7:0] d;} ascp_row_s;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_dat_w = 32'h0;
   logic [31:0] wb_dat_r;
   logic wb_ack;
   logic sdo_strap = 1'b0;
   logic sclk_strap = 1'b0;
   logic duty_cycle_stabiliser, twos, hiz, pd, strap_mode, lsb_first;
   logic sck_q = 1'b0;
   logic [23:0] cap = 24'h0;
   logic [31:0] t;
   logic [7:0] q;
   int failures = 0;
   int n_tests = 0;
   ascp_row_s rows [4] = '{'{13'h0002, 8'hA5}, '{13'h0015, 8'h5A}, '{13'h003F, 8'hFF},
      '{13'h0020, 8'h3C}};
   ascp_if link_if ();
   assign link_if.mon_sdo_strap = sdo_strap;
   assign link_if.mon_sclk_strap = sclk_strap;
   ascp_host ascp_host_i (.clk_i(clk_i), .rst_i(rst_i), .link(link_if.host), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack));
   ascp_device ascp_device_i (.clk_i(clk_i), .rst_i(rst_i), .link(link_if.device),
      .duty_cycle_stabiliser_o(duty_cycle_stabiliser), .twos_complement_o(twos), .outputs_hiz_o(hiz),
      .power_down_o(pd), .strap_mode_o(strap_mode), .lsb_first_o(lsb_first));
   ascp_checker ascp_checker_i (.clk_i(clk_i), .rst_i(rst_i),
      .port_select_n(link_if.port_select_n), .shift_clock(link_if.shift_clock),
      .sdio_host_o(link_if.sdio_host_o), .sdio_host_oe(link_if.sdio_host_oe),
      .sdio_dev_o(link_if.sdio_dev_o), .sdio_dev_oe(link_if.sdio_dev_oe));
   always #50 clk_i = ~clk_i;
   // ----------
   // wire monitor: last 24 bits seen on rising shift clock
   // ----------
   always @(posedge clk_i)
   begin
      sck_q <= link_if.shift_clock;
      if (link_if.shift_clock && !sck_q && !link_if.port_select_n)
         cap <= {cap[22:0], link_if.sdio_line};
   end
   // ----------
   // tasks
   // ----------
   task automatic stop_test();
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      int n;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_sel <= 4'hF;
      wb_dat_w <= d;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 20);
      r = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (wb_ack !== 1'b1)
      begin
         failures++;
         stop_test();
      end
   endtask
   // one single-byte frame; WDATA is loaded for reads too, it is ignored then
   task automatic spi(input logic rd, input logic lsb, input logic [12:0] a,
      input logic [7:0] d, output logic [7:0] r);
      int n;
      wb_xfer(1'b1, ascp_pkg::WB_ADDR, {19'h0, a}, t);
      wb_xfer(1'b1, ascp_pkg::WB_WDATA, {24'h0, d}, t);
      wb_xfer(1'b1, ascp_pkg::WB_CTRL, {29'h0, lsb, rd, 1'b1}, t);
      n = 0;
      do
      begin
         wb_xfer(1'b0, ascp_pkg::WB_STATUS, 32'h0, t);
         n++;
      end
      while (t[0] !== 1'b0 && n < 200);
      if (t[0] !== 1'b0)
      begin
         failures++;
         stop_test();
      end
      wb_xfer(1'b0, ascp_pkg::WB_RDATA, 32'h0, t);
      r = t[7:0];
   endtask
   task automatic do_reset(input logic sdo, input logic sclk);
      @(posedge clk_i);
      sdo_strap <= sdo;
      sclk_strap <= sclk;
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (20) @(posedge clk_i);
   endtask
   // ----------
   // sequence
   // ----------
   initial
   begin
      do_reset(1'b1, 1'b0);
      check("strap_mode", strap_mode, 1);
      check("dcs", duty_cycle_stabiliser, 1);
      check("twos", twos, 0);
      check("hiz", hiz, 1);
      check("pd", pd, 0);
      do_reset(1'b0, 1'b1);
      check("hiz", hiz, 0);
      check("pd", pd, 1);
      check("dev_oe", link_if.sdio_dev_oe, 0);
      foreach (rows[i])
      begin
         spi(1'b0, 1'b0, rows[i].a, rows[i].d, q);
      end
      check("wr_frame", cap, {3'b000, rows[3].a, rows[3].d});
      check("strap_left", strap_mode, 0);
      check("sel_idle", link_if.port_select_n, 1);
      foreach (rows[i])
      begin
         spi(1'b1, 1'b0, rows[i].a, 8'h00, q);
         check("rd", q, rows[i].d);
      end
      check("rd_frame", cap, {3'b100, rows[3].a, rows[3].d});
      spi(1'b1, 1'b0, ascp_pkg::ID_ADDR, 8'h00, q);
      check("id", q, ascp_pkg::ID_VALUE);
      spi(1'b1, 1'b0, ascp_pkg::CFG_ADDR, 8'h00, q);
      check("cfg", q, ascp_pkg::CFG_RESET_VALUE);
      check("lsb0", lsb_first, 0);
      spi(1'b0, 1'b0, ascp_pkg::CFG_ADDR, 8'h42, q);
      check("lsb1", lsb_first, 1);
      spi(1'b0, 1'b1, 13'h0011, 8'hB1, q);
      check("lsb_frame", cap, {3'b000, 13'h0011, 8'h8D});
      spi(1'b1, 1'b1, 13'h0011, 8'h00, q);
      check("lsb_rd", q, 8'hB1);
      spi(1'b1, 1'b1, rows[0].a, 8'h00, q);
      check("lsb_old", q, rows[0].d);
      spi(1'b0, 1'b1, ascp_pkg::CFG_ADDR, 8'h24, q);
      check("soft_rst", lsb_first, 0);
      spi(1'b1, 1'b0, ascp_pkg::CFG_ADDR, 8'h00, q);
      check("cfg_back", q, ascp_pkg::CFG_RESET_VALUE);
      wb_xfer(1'b0, 8'h14, 32'h0, t);
      check("unmapped", t, 32'h0);
      stop_test();
   end
endmodule // tb_adc_serial_config_port
`default_nettype wire
